// file: rtl/spw_pkg.sv
// constants and types shared by the eight-channel scalable pwm block
// assumes a 32-bit apb slave port; register index times four is the
// byte address
package spw_pkg;
  // ==========================================================
  // geometry
  localparam int SPW_NCH = 8;
  localparam int SPW_NPAIR = 4;
  localparam int SPW_PRESC_W = 7;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [5:0] SPW_IDX_ENABLE = 6'h00;
  localparam logic [5:0] SPW_IDX_POL = 6'h01;
  localparam logic [5:0] SPW_IDX_CLK = 6'h02;
  localparam logic [5:0] SPW_IDX_PRCLK = 6'h03;
  localparam logic [5:0] SPW_IDX_CAE = 6'h04;
  localparam logic [5:0] SPW_IDX_CTL = 6'h05;
  localparam logic [5:0] SPW_IDX_CNT = 6'h08;
  localparam logic [5:0] SPW_IDX_PER = 6'h10;
  localparam logic [5:0] SPW_IDX_DTY = 6'h18;
  // ==========================================================
  // field layouts and reset values
  localparam logic [7:0] SPW_PRCLK_MASK = 8'h77;
  localparam logic [7:0] SPW_CTL_MASK = 8'hFC;
  localparam int SPW_CTL_JOIN_LSB = 4;
  localparam int SPW_CLOCK_A_PRESCALE_LSB = 0;
  localparam int SPW_CLOCK_B_PRESCALE_LSB = 4;
  localparam logic [7:0] SPW_REG_RST = 8'h00;
  localparam logic [15:0] SPW_CNT_ONE = 16'h0001;
  // ==========================================================
  // result of one channel step
  typedef struct packed {
    logic [15:0] cnt;
    logic down;
    logic out;
    logic load;
  } spw_step_s;
endpackage : spw_pkg

// file: rtl/spw_top.sv
// eight-channel scalable pwm with apb register access
// assumes apb master on pclk; waveform pins feed external circuitry
//
// Overview of operation
// (RULE1) eight 8-bit channels, or four 16-bit channels when pairs join
// (RULE2) reading a channel counter returns the count, disturbing nothing
// (RULE3) counter write clears it, counts up, loads buffers, output from polarity
// (RULE4) while enable bit is zero the counter holds its value
// (RULE5) on re-enable the counter resumes from the held value
// (RULE6) disabled channel with zero period resets counter on next tick
// (RULE7) counter write while enabled restarts the period at once
// (RULE8) counter clears at the end of the effective period
// (RULE9) center-align bit zero selects left-aligned output
// (RULE10) left-aligned counts up only, compared with duty and period
// (RULE11) left-aligned duty match toggles the output flip-flop
// (RULE12) period match resets counter and output, loads buffered values
// (RULE13) left-aligned counter runs zero through period minus one
// (RULE14) four join bits each make one channel pair sixteen bits
// (RULE15) even channel holds high bytes, odd channel low bytes
// (RULE16) joined pair uses the odd channel clock choice
// (RULE17) joined waveform leaves on odd pin with odd channel polarity
// (RULE18) software changes join bits only with both channels disabled
// (RULE19) reserved bits read zero and ignore writes
// (RULE20) center-aligned counts up to period then down, toggling on duty
// (RULE21) polarity one starts high and falls on duty match
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module spw_top
  import spw_pkg::*;
#(
  parameter int AW = 12
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [SPW_NCH-1:0] pwm_out
);
  // ==========================================================
  // state
  logic [7:0] chan_enable_bit_q, chan_enable_bit_d;
  logic [7:0] chan_polarity_bit_q, chan_polarity_bit_d;
  logic [7:0] chan_clock_choice_bit_q, chan_clock_choice_bit_d;
  logic [7:0] prescale_q, prescale_d;
  logic [7:0] chan_center_align_bit_q, chan_center_align_bit_d;
  logic [7:0] ctl_q, ctl_d;
  logic [7:0] per_buf_q [SPW_NCH];
  logic [7:0] per_buf_d [SPW_NCH];
  logic [7:0] dty_buf_q [SPW_NCH];
  logic [7:0] dty_buf_d [SPW_NCH];
  logic [7:0] chan_period_value_q [SPW_NCH];
  logic [7:0] chan_period_value_d [SPW_NCH];
  logic [7:0] chan_duty_value_q [SPW_NCH];
  logic [7:0] chan_duty_value_d [SPW_NCH];
  logic [7:0] chan_counter_q [SPW_NCH];
  logic [7:0] chan_counter_d [SPW_NCH];
  logic [SPW_NCH-1:0] down_q, down_d;
  logic [SPW_NCH-1:0] out_q, out_d;
  logic [SPW_PRESC_W-1:0] presc_q, presc_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [5:0] idx;
  logic mapped, wr_en, rd_first;
  logic [SPW_NCH-1:0] wr_cnt;
  logic [SPW_NPAIR-1:0] join_pair;
  logic [SPW_PRESC_W-1:0] mask_a, mask_b;
  logic tick_a, tick_b;
  logic [SPW_NCH-1:0] tick_ch;
  logic [7:0] rd_byte;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pwm_out = out_q;

  // ==========================================================
  // one channel step: wide enough for a joined pair, 8-bit values
  // simply arrive zero-extended so one datapath serves both modes
  function automatic spw_step_s chan_step(
    input logic [15:0] cnt,
    input logic [15:0] per,
    input logic [15:0] dty,
    input logic down,
    input logic out,
    input logic pol,
    input logic cae,
    input logic tick,
    input logic en,
    input logic wr,
    input logic per_zero
  );
    spw_step_s r;
    logic [15:0] n;
    r.cnt = cnt;
    r.down = down;
    r.out = out;
    r.load = 1'b0;
    n = cnt;
    // (RULE3) counter write restart
    // (RULE7) also restarts an enabled channel at once
    if (wr)
    begin
      r.cnt = '0;
      r.down = 1'b0;
      r.out = pol;
      r.load = 1'b1;
    end
    // (RULE6) zero period reset
    else if (tick && !en && per_zero)
    begin
      r.cnt = '0;
    end
    // (RULE4) hold when disabled; (RULE5) resume from held count
    else if (tick && en)
    begin
      // (RULE9) alignment select
      if (!cae)
      begin
        // (RULE10) up count only; (RULE13) wrap at period minus one
        n = cnt + SPW_CNT_ONE;
        if (n >= per)
        begin
          // (RULE12) period match; (RULE8) clear at period end
          r.cnt = '0;
          r.out = pol;
          r.load = 1'b1;
        end
        else
        begin
          r.cnt = n;
          // (RULE11) duty toggle; (RULE21) leaves polarity level
          if (n == dty)
            r.out = ~out;
        end
      end
      else if (!down)
      begin
        // (RULE20) up leg stops at period
        n = cnt + SPW_CNT_ONE;
        if (n >= per)
        begin
          n = per;
          r.down = 1'b1;
        end
        r.cnt = n;
        if (n == dty)
          r.out = ~out;
      end
      else if (cnt <= SPW_CNT_ONE)
      begin
        // (RULE20) down leg ends at zero; (RULE8) period end
        r.cnt = '0;
        r.down = 1'b0;
        r.out = pol;
        r.load = 1'b1;
      end
      else
      begin
        n = cnt - SPW_CNT_ONE;
        r.cnt = n;
        if (n == dty)
          r.out = ~out;
      end
    end
    return r;
  endfunction : chan_step

  // ==========================================================
  // apb decode: one wait state, so every output comes from a flop
  assign idx = paddr[7:2];
  assign mapped = (paddr[AW-1:8] == '0) &&
                  ((idx <= SPW_IDX_CTL) || (idx >= SPW_IDX_CNT &&
                   idx < SPW_IDX_DTY + 6'(SPW_NCH)));
  assign wr_en = psel && penable && pwrite && pready_q;
  assign rd_first = psel && penable && !pready_q;
  // (RULE14) one join bit per pair, pair zero in the lowest bit
  assign join_pair = ctl_q[SPW_CTL_JOIN_LSB +: SPW_NPAIR];

  // read mux; (RULE2) reading the counter is free of side effects
  always_comb
  begin
    rd_byte = SPW_REG_RST;
    for (int c = 0; c < SPW_NCH; c++)
    begin
      if (idx == SPW_IDX_CNT + 6'(c))
        rd_byte = chan_counter_q[c];
      if (idx == SPW_IDX_PER + 6'(c))
        rd_byte = per_buf_q[c];
      if (idx == SPW_IDX_DTY + 6'(c))
        rd_byte = dty_buf_q[c];
    end
    case (idx)
      SPW_IDX_ENABLE: rd_byte = chan_enable_bit_q;
      SPW_IDX_POL: rd_byte = chan_polarity_bit_q;
      SPW_IDX_CLK: rd_byte = chan_clock_choice_bit_q;
      SPW_IDX_PRCLK: rd_byte = prescale_q;
      SPW_IDX_CAE: rd_byte = chan_center_align_bit_q;
      SPW_IDX_CTL: rd_byte = ctl_q;
      default: ;
    endcase
  end

  // register writes and bus answer
  always_comb
  begin
    chan_enable_bit_d = chan_enable_bit_q;
    chan_polarity_bit_d = chan_polarity_bit_q;
    chan_clock_choice_bit_d = chan_clock_choice_bit_q;
    prescale_d = prescale_q;
    chan_center_align_bit_d = chan_center_align_bit_q;
    ctl_d = ctl_q;
    per_buf_d = per_buf_q;
    dty_buf_d = dty_buf_q;
    wr_cnt = '0;
    pready_d = rd_first;
    pslverr_d = rd_first && !mapped;
    prdata_d = '0;
    // (RULE19) upper 24 bits always zero
    if (rd_first && !pwrite && mapped)
      prdata_d = {24'h000000, rd_byte};
    if (wr_en && mapped)
    begin
      // (RULE19) reserved bits masked on write
      case (idx)
        SPW_IDX_ENABLE: chan_enable_bit_d = pwdata[7:0];
        SPW_IDX_POL: chan_polarity_bit_d = pwdata[7:0];
        SPW_IDX_CLK: chan_clock_choice_bit_d = pwdata[7:0];
        SPW_IDX_PRCLK: prescale_d = pwdata[7:0] & SPW_PRCLK_MASK;
        SPW_IDX_CAE: chan_center_align_bit_d = pwdata[7:0];
        SPW_IDX_CTL: ctl_d = pwdata[7:0] & SPW_CTL_MASK;
        default: ;
      endcase
      for (int c = 0; c < SPW_NCH; c++)
      begin
        if (idx == SPW_IDX_CNT + 6'(c))
          wr_cnt[c] = 1'b1;
        if (idx == SPW_IDX_PER + 6'(c))
          per_buf_d[c] = pwdata[7:0];
        if (idx == SPW_IDX_DTY + 6'(c))
          dty_buf_d[c] = pwdata[7:0];
      end
    end
  end

  // ==========================================================
  // prescaler: clock a and clock b tick every 2^n pclk cycles
  assign mask_a = SPW_PRESC_W'((8'h01 << prescale_q[SPW_CLOCK_A_PRESCALE_LSB +: 3])
                  - 8'h01);
  assign mask_b = SPW_PRESC_W'((8'h01 << prescale_q[SPW_CLOCK_B_PRESCALE_LSB +: 3])
                  - 8'h01);
  assign tick_a = (presc_q & mask_a) == mask_a;
  assign tick_b = (presc_q & mask_b) == mask_b;
  assign presc_d = presc_q + SPW_PRESC_W'(1);
  always_comb
  begin
    for (int c = 0; c < SPW_NCH; c++)
      tick_ch[c] = chan_clock_choice_bit_q[c] ? tick_b : tick_a;
  end

  // ==========================================================
  // channel datapath, one pair at a time
  always_comb
  begin
    spw_step_s r;
    int hi;
    int lo;
    int c;
    r = '0;
    hi = 0;
    lo = 0;
    c = 0;
    chan_counter_d = chan_counter_q;
    chan_period_value_d = chan_period_value_q;
    chan_duty_value_d = chan_duty_value_q;
    down_d = down_q;
    out_d = out_q;
    for (int p = 0; p < SPW_NPAIR; p++)
    begin
      hi = 2 * p;
      lo = 2 * p + 1;
      if (join_pair[p])
      begin
        // (RULE15) even bytes high; (RULE16) odd clock choice
        // (RULE17) odd polarity and odd pin
        r = chan_step({chan_counter_q[hi], chan_counter_q[lo]},
          {chan_period_value_q[hi], chan_period_value_q[lo]},
          {chan_duty_value_q[hi], chan_duty_value_q[lo]},
          down_q[lo], out_q[lo], chan_polarity_bit_q[lo],
          chan_center_align_bit_q[lo], tick_ch[lo],
          chan_enable_bit_q[lo], wr_cnt[hi] | wr_cnt[lo],
          {per_buf_q[hi], per_buf_q[lo]} == 16'h0000);
        chan_counter_d[hi] = r.cnt[15:8];
        chan_counter_d[lo] = r.cnt[7:0];
        down_d[lo] = r.down;
        out_d[lo] = r.out;
        // (RULE12) buffers into active at period boundary
        if (r.load || !chan_enable_bit_q[lo])
        begin
          chan_period_value_d[hi] = per_buf_q[hi];
          chan_period_value_d[lo] = per_buf_q[lo];
          chan_duty_value_d[hi] = dty_buf_q[hi];
          chan_duty_value_d[lo] = dty_buf_q[lo];
        end
      end
      else
      begin
        // (RULE1) two independent 8-bit channels
        for (int k = 0; k < 2; k++)
        begin
          c = hi + k;
          r = chan_step({8'h00, chan_counter_q[c]},
            {8'h00, chan_period_value_q[c]},
            {8'h00, chan_duty_value_q[c]},
            down_q[c], out_q[c], chan_polarity_bit_q[c],
            chan_center_align_bit_q[c], tick_ch[c],
            chan_enable_bit_q[c], wr_cnt[c], per_buf_q[c] == 8'h00);
          chan_counter_d[c] = r.cnt[7:0];
          down_d[c] = r.down;
          out_d[c] = r.out;
          if (r.load || !chan_enable_bit_q[c])
          begin
            chan_period_value_d[c] = per_buf_q[c];
            chan_duty_value_d[c] = dty_buf_q[c];
          end
        end
      end
    end
  end

  // ==========================================================
  // all state registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chan_enable_bit_q <= SPW_REG_RST;
      chan_polarity_bit_q <= SPW_REG_RST;
      chan_clock_choice_bit_q <= SPW_REG_RST;
      prescale_q <= SPW_REG_RST;
      chan_center_align_bit_q <= SPW_REG_RST;
      ctl_q <= SPW_REG_RST;
      for (int c = 0; c < SPW_NCH; c++)
      begin
        per_buf_q[c] <= SPW_REG_RST;
        dty_buf_q[c] <= SPW_REG_RST;
        chan_period_value_q[c] <= SPW_REG_RST;
        chan_duty_value_q[c] <= SPW_REG_RST;
        chan_counter_q[c] <= SPW_REG_RST;
      end
      down_q <= '0;
      out_q <= '0;
      presc_q <= '0;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      chan_enable_bit_q <= chan_enable_bit_d;
      chan_polarity_bit_q <= chan_polarity_bit_d;
      chan_clock_choice_bit_q <= chan_clock_choice_bit_d;
      prescale_q <= prescale_d;
      chan_center_align_bit_q <= chan_center_align_bit_d;
      ctl_q <= ctl_d;
      per_buf_q <= per_buf_d;
      dty_buf_q <= dty_buf_d;
      chan_period_value_q <= chan_period_value_d;
      chan_duty_value_q <= chan_duty_value_d;
      chan_counter_q <= chan_counter_d;
      down_q <= down_d;
      out_q <= out_d;
      presc_q <= presc_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ==========================================================
  // assertions, watched on channel 1 running unjoined; a_read_cnt and a_reserved watch bus accesses
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic c1_solo;
  logic [7:0] c1_next;
  assign c1_solo = !join_pair[0] && !wr_cnt[1] && tick_ch[1];
  assign c1_next = chan_counter_q[1] + 8'h01;

  sequence s_access;
    rd_first ##1 pready_q;
  endsequence
  sequence s_left_run;
    c1_solo && chan_enable_bit_q[1] && !chan_center_align_bit_q[1];
  endsequence

  property p_cnt_write;
    (wr_cnt[1] && !join_pair[0]) |=> (chan_counter_q[1] == 8'h00) &&
      !down_q[1] && (out_q[1] == $past(chan_polarity_bit_q[1]));
  endproperty
  a_cnt_write: assert property (p_cnt_write) // (RULE3)
    else $error("counter write did not restart channel 1");

  property p_hold;
    (!join_pair[0] && !wr_cnt[1] && !chan_enable_bit_q[1] &&
      per_buf_q[1] != 8'h00) |=> $stable(chan_counter_q[1]);
  endproperty
  a_hold: assert property (p_hold) // (RULE4)
    else $error("disabled channel 1 counter moved");

  property p_per_zero;
    (c1_solo && !chan_enable_bit_q[1] && per_buf_q[1] == 8'h00)
      |=> chan_counter_q[1] == 8'h00;
  endproperty
  a_per_zero: assert property (p_per_zero) // (RULE6)
    else $error("zero period did not reset disabled counter");

  property p_left_step;
    (s_left_run and (c1_next < chan_period_value_q[1]))
      |=> chan_counter_q[1] == $past(c1_next);
  endproperty
  a_left_step: assert property (p_left_step) // (RULE10)
    else $error("left-aligned counter did not step up");

  property p_left_wrap;
    (s_left_run and (c1_next >= chan_period_value_q[1]))
      |=> chan_counter_q[1] == 8'h00 &&
        out_q[1] == $past(chan_polarity_bit_q[1]) &&
        chan_period_value_q[1] == $past(per_buf_q[1]);
  endproperty
  a_left_wrap: assert property (p_left_wrap) // (RULE13)
    else $error("left-aligned wrap wrong");

  property p_duty_toggle;
    (s_left_run and (c1_next < chan_period_value_q[1]) and
      (c1_next == chan_duty_value_q[1])) |=> out_q[1] != $past(out_q[1]);
  endproperty
  a_duty_toggle: assert property (p_duty_toggle) // (RULE11)
    else $error("duty match did not toggle output");

  property p_center_down;
    (c1_solo && chan_enable_bit_q[1] && chan_center_align_bit_q[1] &&
      down_q[1] && chan_counter_q[1] > 8'h01)
      |=> chan_counter_q[1] == $past(chan_counter_q[1]) - 8'h01;
  endproperty
  a_center_down: assert property (p_center_down) // (RULE20)
    else $error("center-aligned down count wrong");

  property p_read_cnt;
    (rd_first && !pwrite && paddr == AW'({SPW_IDX_CNT + 6'h01, 2'b00}))
      |=> prdata_q == {24'h000000, $past(chan_counter_q[1])};
  endproperty
  a_read_cnt: assert property (p_read_cnt) // (RULE2)
    else $error("counter read returned wrong value");

  property p_reserved;
    s_access |-> prdata_q[31:8] == 24'h000000 &&
      (ctl_q & ~SPW_CTL_MASK) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) // (RULE19)
    else $error("reserved bits not zero");
endmodule : spw_top

// file: test/spw_pin_monitor.sv
// passive load on the eight waveform pins: counts the high cycles and the
// rising edges of one chosen pin over a window of pclk cycles
// assumes the pins are registered on pclk and settle between edges
`timescale 1ns/1ps
module spw_pin_monitor
  import spw_pkg::*;
(
  input wire logic pclk,
  input wire logic [SPW_NCH-1:0] pwm_out,
  input wire logic [2:0] sel,
  input wire logic start,
  input wire logic [15:0] span,
  output logic busy,
  output logic [15:0] hi_cnt,
  output logic [15:0] rise_cnt
);
  logic pin;
  logic last_q;
  logic [15:0] left_q, left_d, hi_q, hi_d, rise_q, rise_d;
  // ==========================================================
  // window counters
  // a load only listens, so it never disturbs the waveform it measures
  always_comb
  begin
    pin = pwm_out[sel];
    left_d = left_q;
    hi_d = hi_q;
    rise_d = rise_q;
    if (start)
    begin
      left_d = span;
      hi_d = 16'h0000;
      rise_d = 16'h0000;
    end
    else if (left_q != 16'h0000)
    begin
      left_d = left_q - 16'h0001;
      hi_d = hi_q + {15'h0000, pin};
      rise_d = rise_q + {15'h0000, pin & ~last_q};
    end
  end
  // edge detect keeps running outside windows so the first cycle is fair
  always_ff @(posedge pclk)
  begin
    last_q <= pin;
    left_q <= left_d;
    hi_q <= hi_d;
    rise_q <= rise_d;
  end
  assign busy = (left_q != 16'h0000);
  assign hi_cnt = hi_q;
  assign rise_cnt = rise_q;
endmodule : spw_pin_monitor

// file: test/tb_top.sv
// self-checking bench for the eight-channel pwm: apb register table,
// left and center waveforms, hold and clear of counters, joined pair
// assumes pwm clock A and B prescalers of 2^n pclk cycles
`timescale 1ns/1ps
module tb_top;
  import spw_pkg::*;
  typedef struct {logic [5:0] idx; logic [7:0] wd; logic [7:0] rd; logic err;}
    spw_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic mon_start, mon_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, hold;
  logic [SPW_NCH-1:0] pwm_out;
  logic [2:0] mon_sel;
  logic [15:0] mon_span, mon_hi, mon_rise;
  int errors, num_checks;
  spw_row_s rows[10] = '{
    '{SPW_IDX_ENABLE, 8'h00, 8'h00, 1'h0}, '{SPW_IDX_POL, 8'hA5, 8'hA5, 1'h0},
    '{SPW_IDX_CLK, 8'h5A, 8'h5A, 1'h0}, '{SPW_IDX_PRCLK, 8'hFF, 8'h77, 1'h0},
    '{SPW_IDX_CAE, 8'h3C, 8'h3C, 1'h0}, '{SPW_IDX_CTL, 8'hFF, 8'hFC, 1'h0},
    '{SPW_IDX_CNT, 8'h33, 8'h00, 1'h0}, '{6'h13, 8'h80, 8'h80, 1'h0},
    '{6'h1F, 8'h7E, 8'h7E, 1'h0}, '{6'h06, 8'hFF, 8'h00, 1'h1}};

  spw_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out));
  spw_pin_monitor mon (.pclk(pclk), .pwm_out(pwm_out), .sel(mon_sel),
    .start(mon_start), .span(mon_span), .busy(mon_busy), .hi_cnt(mon_hi),
    .rise_cnt(mon_rise));

  always #2 pclk = ~pclk;

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; entered just after a rising edge, waits for pready
  task automatic apb(input logic wr, input logic [5:0] idx,
    input logic [7:0] wd);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= {4'h0, idx, 2'h0};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'h1;
    // no cycle count assumed here: only the watchdog ends a stuck wait
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    check({8'h00, prdata[31:8]}, 32'h0);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  // measure one pin over a window of whole periods
  task automatic measure(input logic [2:0] ch, input logic [15:0] span,
    input logic [15:0] hi, input logic [15:0] rise);
    int n;
    repeat (16) @(posedge pclk);
    mon_sel <= ch;
    mon_span <= span;
    mon_start <= 1'h1;
    @(posedge pclk);
    mon_start <= 1'h0;
    @(posedge pclk);
    n = 0;
    while (mon_busy === 1'h1 && n < 4000)
    begin
      @(posedge pclk);
      n = n + 1;
    end
    check({16'h0, mon_hi}, {16'h0, hi});
    check({16'h0, mon_rise}, {16'h0, rise});
  endtask : measure

  // ==========================================================
  // watchdog
  initial
  begin
    #200000;
    errors = errors + 1;
    $display("watchdog expired");
    end_of_test();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    pclk = 1'h0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mon_sel = 3'h0;
    mon_start = 1'h0;
    mon_span = 16'h0;
    errors = 0;
    num_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    // register table: reset value, write, read back
    foreach (rows[i])
    begin
      apb(1'h0, rows[i].idx, 8'h00);
      check(rdat, {24'h0, SPW_REG_RST});
      apb(1'h1, rows[i].idx, rows[i].wd);
      apb(1'h0, rows[i].idx, 8'h00);
      check(rdat, {24'h0, rows[i].rd});
      check({31'h0, rerr}, {31'h0, rows[i].err});
    end
    for (int i = 0; i < 6; i++)
      apb(1'h1, i[5:0], 8'h00);
    $display("test registers done");
    // left aligned channel 0, period 4, duty 1, clock A undivided
    apb(1'h1, SPW_IDX_POL, 8'h01);
    apb(1'h1, SPW_IDX_PER, 8'h04);
    apb(1'h1, SPW_IDX_DTY, 8'h01);
    apb(1'h1, SPW_IDX_CNT, 8'h00);
    apb(1'h1, SPW_IDX_ENABLE, 8'h01);
    measure(3'h0, 16'h0028, 16'h000A, 16'h000A);
    apb(1'h1, SPW_IDX_POL, 8'h00);
    measure(3'h0, 16'h0028, 16'h001E, 16'h000A);
    apb(1'h0, SPW_IDX_CNT, 8'h00);
    check({31'h0, rdat < 32'h4}, 32'h1);
    $display("test left aligned done");
    // stopped counter holds; a counter write clears it and drives the pin low
    apb(1'h1, SPW_IDX_PER, 8'hC8);
    repeat (60) @(posedge pclk);
    apb(1'h1, SPW_IDX_ENABLE, 8'h00);
    apb(1'h0, SPW_IDX_CNT, 8'h00);
    hold = rdat;
    repeat (20) @(posedge pclk);
    apb(1'h0, SPW_IDX_CNT, 8'h00);
    check(rdat, hold);
    // re-enabled counter goes on from the held count, two ticks later
    apb(1'h1, SPW_IDX_ENABLE, 8'h01);
    apb(1'h0, SPW_IDX_CNT, 8'h00);
    check(rdat, hold + 32'h2);
    apb(1'h1, SPW_IDX_ENABLE, 8'h00);
    // pin sits high after the duty match, so a low result is a real change
    apb(1'h1, SPW_IDX_POL, 8'h00);
    apb(1'h1, SPW_IDX_CNT, 8'h55);
    check({31'h0, pwm_out[0]}, 32'h0);
    apb(1'h0, SPW_IDX_CNT, 8'h00);
    check(rdat, 32'h0);
    apb(1'h1, SPW_IDX_ENABLE, 8'h01);
    repeat (30) @(posedge pclk);
    // counter write while running restarts the period at once
    apb(1'h1, SPW_IDX_CNT, 8'hAA);
    check({31'h0, pwm_out[0]}, 32'h0);
    apb(1'h0, SPW_IDX_CNT, 8'h00);
    check(rdat, 32'h2);
    apb(1'h1, SPW_IDX_ENABLE, 8'h00);
    apb(1'h1, SPW_IDX_PER, 8'h00);
    repeat (4) @(posedge pclk);
    apb(1'h0, SPW_IDX_CNT, 8'h00);
    check(rdat, 32'h0);
    $display("test hold and clear done");
    // center aligned channel 2: period 8 cycles, high 2 of them
    apb(1'h1, SPW_IDX_POL, 8'h04);
    apb(1'h1, SPW_IDX_CAE, 8'h04);
    apb(1'h1, SPW_IDX_PER + 6'h02, 8'h04);
    apb(1'h1, SPW_IDX_DTY + 6'h02, 8'h01);
    apb(1'h1, SPW_IDX_CNT + 6'h02, 8'h00);
    apb(1'h1, SPW_IDX_ENABLE, 8'h04);
    measure(3'h2, 16'h0050, 16'h0014, 16'h000A);
    apb(1'h1, SPW_IDX_ENABLE, 8'h00);
    $display("test center aligned done");
    // joined pair 0/1 changed while both are off; even clock runs slow
    apb(1'h1, SPW_IDX_CTL, 8'h10);
    apb(1'h1, SPW_IDX_CLK, 8'h01);
    apb(1'h1, SPW_IDX_PRCLK, 8'h70);
    apb(1'h1, SPW_IDX_CAE, 8'h00);
    apb(1'h1, SPW_IDX_PER, 8'h01);
    apb(1'h1, SPW_IDX_PER + 6'h01, 8'h00);
    apb(1'h1, SPW_IDX_DTY, 8'h00);
    apb(1'h1, SPW_IDX_DTY + 6'h01, 8'h40);
    apb(1'h1, SPW_IDX_POL, 8'h02);
    apb(1'h1, SPW_IDX_CNT + 6'h01, 8'h00);
    apb(1'h1, SPW_IDX_ENABLE, 8'h02);
    measure(3'h1, 16'h0200, 16'h0080, 16'h0002);
    $display("test joined pair done");
    // channel 1 alone again, split while both halves are off
    apb(1'h1, SPW_IDX_ENABLE, 8'h00);
    apb(1'h1, SPW_IDX_CTL, 8'h00);
    apb(1'h1, SPW_IDX_PER + 6'h01, 8'h03);
    apb(1'h1, SPW_IDX_DTY + 6'h01, 8'h02);
    apb(1'h1, SPW_IDX_CNT + 6'h01, 8'h00);
    apb(1'h1, SPW_IDX_ENABLE, 8'h02);
    measure(3'h1, 16'h001E, 16'h0014, 16'h000A);
    apb(1'h0, SPW_IDX_CNT + 6'h01, 8'h00);
    check({31'h0, rdat < 32'h3}, 32'h1);
    apb(1'h1, SPW_IDX_CAE, 8'h02);
    measure(3'h1, 16'h0024, 16'h0018, 16'h0006);
    $display("test single channel done");
    // reset in mid-run: pins drop at once, registers read back zero
    presetn <= 1'h0;
    @(posedge pclk);
    check({24'h0, pwm_out}, 32'h0);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, SPW_IDX_ENABLE, 8'h00);
    check(rdat, 32'h0);
    apb(1'h0, SPW_IDX_CNT + 6'h01, 8'h00);
    check(rdat, 32'h0);
    $display("test reset done");
    end_of_test();
  end
endmodule : tb_top
